//--- common/cca_chan_if.sv
// Interface between the counter array top and one compare/capture module
interface cca_chan_if;
    import cca_pkg::*;
    logic [15:0] cnt;       // Shared counter value
    logic        tick;      // Counter advances this cycle
    logic        low_ovf;   // Low byte wraps this cycle
    logic [7:0]  wdata;     // Bus write data
    logic        wr_mode;   // Write strobe for mode register
    logic        wr_hi;     // Write strobe for high capture byte
    logic        wr_lo;     // Write strobe for low capture byte
    logic        wr_flag;   // Write strobe for event flag (wdata bit is new value)
    logic        flag_bit;  // Flag value carried with wr_flag
    logic        rise;      // Synchronised rising edge of module pin
    logic        fall;      // Synchronised falling edge of module pin
    logic [6:0]  mode;      // Mode register contents
    logic [7:0]  cap_hi;    // High compare/capture byte
    logic [7:0]  cap_lo;    // Low compare/capture byte
    logic        flag;      // Event flag
    logic        pin_out;   // Module pin level
    logic        pin_oe;    // Module pin drive enable
    logic        irq;       // Gated interrupt request

    modport ctl (output cnt, tick, low_ovf, wdata, wr_mode, wr_hi, wr_lo, wr_flag, flag_bit,
                 rise, fall, input mode, cap_hi, cap_lo, flag, pin_out, pin_oe, irq);
    modport chan (input cnt, tick, low_ovf, wdata, wr_mode, wr_hi, wr_lo, wr_flag, flag_bit,
                  rise, fall, output mode, cap_hi, cap_lo, flag, pin_out, pin_oe, irq);
endinterface

//--- common/cca_pkg.sv
// Package with register map, field positions and reset values of the counter array
package cca_pkg;
    // ------------------------------------------------------------
    // Register addresses on the special function register bus
    // ------------------------------------------------------------
    localparam logic [7:0] CCA_ADDR_CONTROL = 8'hD8;
    localparam logic [7:0] CCA_ADDR_MODE0   = 8'hDA;
    localparam logic [7:0] CCA_ADDR_MODE1   = 8'hDB;
    localparam logic [7:0] CCA_ADDR_CNT_LO  = 8'hE9;
    localparam logic [7:0] CCA_ADDR_CAP0_LO = 8'hEA;
    localparam logic [7:0] CCA_ADDR_CAP1_LO = 8'hEB;
    localparam logic [7:0] CCA_ADDR_CNT_HI  = 8'hF9;
    localparam logic [7:0] CCA_ADDR_CAP0_HI = 8'hFA;
    localparam logic [7:0] CCA_ADDR_CAP1_HI = 8'hFB;

    // ------------------------------------------------------------
    // Mode register field positions
    // ------------------------------------------------------------
    localparam int CCA_MODE_COMPARE_EN = 6;
    localparam int CCA_MODE_RISE_CAP   = 5;
    localparam int CCA_MODE_FALL_CAP   = 4;
    localparam int CCA_MODE_MATCH_FLAG = 3;
    localparam int CCA_MODE_TOGGLE     = 2;
    localparam int CCA_MODE_PWM        = 1;
    localparam int CCA_MODE_IRQ_EN     = 0;
    localparam int CCA_MODE_BITS       = 7;

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int CCA_CTRL_OVF = 7;
    localparam int CCA_CTRL_RUN = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [6:0]  CCA_MODE_RESET = 7'h00;
    localparam logic [7:0]  CCA_BYTE_RESET = 8'h00;
    localparam logic [15:0] CCA_CNT_RESET  = 16'h0000;
endpackage

//--- design/cca_module.sv
// One compare/capture module: mode, capture pair, event flag and pin driver
module cca_module
    import cca_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    cca_chan_if.chan  ch
);
    typedef struct packed {
        logic [6:0] mode;
        logic [7:0] cap_hi;
        logic [7:0] cap_lo;
        logic       flag;
        logic       pin;
        logic       oe;
        logic       irq;
    } cca_mod_state_t;

    cca_mod_state_t s;
    cca_mod_state_t next_s;
    logic           match;
    logic           capture;
    logic           pwm;

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    // Match only on an increment, so a stopped counter does not re-flag forever
    assign match   = ch.tick && s.mode[CCA_MODE_COMPARE_EN]
                     && (ch.cnt == {s.cap_hi, s.cap_lo});
    assign capture = (ch.rise && s.mode[CCA_MODE_RISE_CAP])
                     || (ch.fall && s.mode[CCA_MODE_FALL_CAP]);
    assign pwm     = s.mode[CCA_MODE_PWM];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        if (ch.wr_mode) begin
            next_s.mode = ch.wdata[6:0];   // Reserved bit 7 is not stored
        end
        if (ch.wr_hi) begin
            next_s.cap_hi = ch.wdata;
        end
        if (ch.wr_lo) begin
            next_s.cap_lo = ch.wdata;
        end
        // PWM duty reload; a software write in the same cycle loses to it
        if (pwm && ch.low_ovf) begin
            next_s.cap_lo = s.cap_hi;
        end
        // Hardware capture beats a software write of the pair
        if (capture) begin
            next_s.cap_hi = ch.cnt[15:8];
            next_s.cap_lo = ch.cnt[7:0];
        end
        // Software write first, so a same-cycle hardware set still wins
        if (ch.wr_flag) begin
            next_s.flag = ch.flag_bit;
        end
        if (capture || (match && s.mode[CCA_MODE_MATCH_FLAG])) begin
            next_s.flag = 1'b1;
        end
        // Pin driver
        if (pwm) begin
            next_s.pin = !(ch.cnt[7:0] < s.cap_lo);
        end else if (match && s.mode[CCA_MODE_MATCH_FLAG] && s.mode[CCA_MODE_TOGGLE]) begin
            next_s.pin = !s.pin;
        end
        next_s.oe  = pwm || (s.mode[CCA_MODE_COMPARE_EN] && s.mode[CCA_MODE_TOGGLE]);
        next_s.irq = s.flag && s.mode[CCA_MODE_IRQ_EN];
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{mode: CCA_MODE_RESET, cap_hi: CCA_BYTE_RESET, cap_lo: CCA_BYTE_RESET,
                   flag: 1'b0, pin: 1'b0, oe: 1'b0, irq: 1'b0};
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign ch.mode    = s.mode;
    assign ch.cap_hi  = s.cap_hi;
    assign ch.cap_lo  = s.cap_lo;
    assign ch.flag    = s.flag;
    assign ch.pin_out = s.pin;
    assign ch.pin_oe  = s.oe;
    assign ch.irq     = s.irq;
endmodule // cca_module

//--- design/cca_top.sv
// Counter array top: shared counter, control register, bus decode and two modules
module cca_top
    import cca_pkg::*;
#(
    parameter int NUM_MOD = 2
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               ce,
    input  wire logic [7:0]         sfr_addr,
    input  wire logic [7:0]         sfr_wdata,
    input  wire logic               sfr_wr,
    input  wire logic               sfr_rd,
    output logic      [7:0]         sfr_rdata,
    input  wire logic [NUM_MOD-1:0] module_io_pin_in,
    output logic      [NUM_MOD-1:0] module_io_pin_out,
    output logic      [NUM_MOD-1:0] module_io_pin_oe,
    output logic      [NUM_MOD-1:0] module_irq_request
);
    typedef struct packed {
        logic [NUM_MOD-1:0] sync1;
        logic [NUM_MOD-1:0] sync2;
        logic [NUM_MOD-1:0] prev;
        logic [15:0]        cnt;
        logic               run;
        logic               ovf;
        logic [7:0]         rdata;
    } cca_top_state_t;

    cca_top_state_t     s;
    cca_top_state_t     next_s;
    logic [6:0]         mode_v    [NUM_MOD];
    logic [7:0]         cap_hi_v  [NUM_MOD];
    logic [7:0]         cap_lo_v  [NUM_MOD];
    logic [NUM_MOD-1:0] flag_v;
    logic               wr_ctrl;
    logic               wr_cnt_lo;
    logic               wr_cnt_hi;

    // ------------------------------------------------------------
    // Write strobe decode for registers held here
    // ------------------------------------------------------------
    assign wr_ctrl   = sfr_wr && (sfr_addr == CCA_ADDR_CONTROL);
    assign wr_cnt_lo = sfr_wr && (sfr_addr == CCA_ADDR_CNT_LO);
    assign wr_cnt_hi = sfr_wr && (sfr_addr == CCA_ADDR_CNT_HI);

    // ------------------------------------------------------------
    // Per-module instances and their strobes
    // ------------------------------------------------------------
    // Module addresses are consecutive, so index i adds to the base address
    genvar i;
    generate
        for (i = 0; i < NUM_MOD; i++) begin : g_mod
            cca_chan_if ch ();

            assign ch.cnt      = s.cnt;
            assign ch.tick     = s.run;
            assign ch.low_ovf  = s.run && (s.cnt[7:0] == 8'hFF);
            assign ch.wdata    = sfr_wdata;
            assign ch.wr_mode  = sfr_wr && (sfr_addr == CCA_ADDR_MODE0 + 8'(i));
            assign ch.wr_hi    = sfr_wr && (sfr_addr == CCA_ADDR_CAP0_HI + 8'(i));
            assign ch.wr_lo    = sfr_wr && (sfr_addr == CCA_ADDR_CAP0_LO + 8'(i));
            assign ch.wr_flag  = wr_ctrl;
            assign ch.flag_bit = sfr_wdata[i];
            // Edges are taken between the second sync stage and its delayed copy
            assign ch.rise     = s.sync2[i] && !s.prev[i];
            assign ch.fall     = !s.sync2[i] && s.prev[i];

            cca_module u_mod (
                .clk   (clk),
                .rst_n (rst_n),
                .ce    (ce),
                .ch    (ch)
            );

            assign mode_v[i]             = ch.mode;
            assign cap_hi_v[i]           = ch.cap_hi;
            assign cap_lo_v[i]           = ch.cap_lo;
            assign flag_v[i]             = ch.flag;
            assign module_io_pin_out[i]  = ch.pin_out;
            assign module_io_pin_oe[i]   = ch.pin_oe;
            assign module_irq_request[i] = ch.irq;
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state: synchronisers, counter, control and read data
    // ------------------------------------------------------------
    always_comb begin
        next_s       = s;
        // Pins are asynchronous; only sync2 and later feed any logic
        next_s.sync1 = module_io_pin_in;
        next_s.sync2 = s.sync1;
        next_s.prev  = s.sync2;

        // Counter advances every enabled cycle while running
        if (s.run) begin
            next_s.cnt = s.cnt + 16'h0001;
        end
        // A byte write overrides the increment of that byte only
        if (wr_cnt_lo) begin
            next_s.cnt[7:0] = sfr_wdata;
        end
        if (wr_cnt_hi) begin
            next_s.cnt[15:8] = sfr_wdata;
        end

        // Control register; hardware overflow set wins over a clear
        if (wr_ctrl) begin
            next_s.run = sfr_wdata[CCA_CTRL_RUN];
            next_s.ovf = sfr_wdata[CCA_CTRL_OVF];
        end
        if (s.run && (s.cnt == 16'hFFFF)) begin
            next_s.ovf = 1'b1;
        end

        // Read data is registered, valid the cycle after sfr_rd
        if (sfr_rd) begin
            case (sfr_addr)
                CCA_ADDR_CONTROL: begin
                    next_s.rdata = {s.ovf, s.run, 4'h0, flag_v[1], flag_v[0]};
                end
                CCA_ADDR_MODE0:   next_s.rdata = {1'b0, mode_v[0]};
                CCA_ADDR_MODE1:   next_s.rdata = {1'b0, mode_v[1]};
                CCA_ADDR_CNT_LO:  next_s.rdata = s.cnt[7:0];
                CCA_ADDR_CNT_HI:  next_s.rdata = s.cnt[15:8];
                CCA_ADDR_CAP0_LO: next_s.rdata = cap_lo_v[0];
                CCA_ADDR_CAP1_LO: next_s.rdata = cap_lo_v[1];
                CCA_ADDR_CAP0_HI: next_s.rdata = cap_hi_v[0];
                CCA_ADDR_CAP1_HI: next_s.rdata = cap_hi_v[1];
                default:          next_s.rdata = 8'h00;  // Unmapped reads zero
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register; clock enable low freezes everything
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Edge history starts at the pulled-up idle level, so no false rise follows reset
            s <= '{sync1: '1, sync2: '1, prev: '1, cnt: CCA_CNT_RESET,
                   run: 1'b0, ovf: 1'b0, rdata: CCA_BYTE_RESET};
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign sfr_rdata = s.rdata;
endmodule // cca_top

//--- test/cca_chk.sv
// Checker bound to the counter array top: readback, counter, toggle and interrupt gating
module cca_chk
    import cca_pkg::*;
#(
    parameter int NUM_MOD = 2
) (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               ce,
    input wire logic [7:0]         sfr_addr,
    input wire logic [7:0]         sfr_wdata,
    input wire logic               sfr_wr,
    input wire logic               sfr_rd,
    input wire logic [7:0]         sfr_rdata,
    input wire logic [NUM_MOD-1:0] module_io_pin_in,
    input wire logic [NUM_MOD-1:0] module_io_pin_out,
    input wire logic [NUM_MOD-1:0] module_io_pin_oe,
    input wire logic [NUM_MOD-1:0] module_irq_request
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // Shadow of software state
    // ------------------------------
    logic [6:0]  m0, m1;
    logic [15:0] cnt, cap0;
    logic        run;
    logic [7:0]  wa, ra;
    // Taken strobes only; address 00 is never mapped
    assign wa = (ce && sfr_wr) ? sfr_addr : 8'h00;
    assign ra = (ce && sfr_rd) ? sfr_addr : 8'h00;
    // Exact while module 0 never captures; a capture into its pair is not shadowed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {m0, m1, cnt, cap0, run} <= '0;
        end else if (ce) begin
            if (wa == CCA_ADDR_MODE0) m0 <= sfr_wdata[6:0];
            if (wa == CCA_ADDR_MODE1) m1 <= sfr_wdata[6:0];
            if (wa == CCA_ADDR_CONTROL) run <= sfr_wdata[CCA_CTRL_RUN];
            if (wa == CCA_ADDR_CAP0_HI) cap0[15:8] <= sfr_wdata;
            // PWM reload beats a software write of the low byte in the same cycle
            if (run && m0[1] && cnt[7:0] == 8'hFF) cap0[7:0] <= cap0[15:8];
            else if (wa == CCA_ADDR_CAP0_LO) cap0[7:0] <= sfr_wdata;
            if (run) cnt <= cnt + 16'h0001;
            if (wa == CCA_ADDR_CNT_HI) cnt[15:8] <= sfr_wdata;
            if (wa == CCA_ADDR_CNT_LO) cnt[7:0] <= sfr_wdata;
        end
    end
    // ------------------------------
    // Properties
    // ------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Module 0 in toggle compare with the counter on its compare pair
    sequence s_match0;
        run && m0[6] && m0[3] && m0[2] && !m0[1] && m0[5:4] == 2'b00 && cnt == cap0;
    endsequence
    // Module 0 with neither compare nor PWM selected
    sequence s_quiet0;
        !m0[6] && !m0[1];
    endsequence
    a_mode0_readback: assert property (
        ra == CCA_ADDR_MODE0 |=> sfr_rdata == {1'b0, $past(m0)}) else $error("mode 0 readback");
    a_mode1_readback: assert property (
        ra == CCA_ADDR_MODE1 |=> sfr_rdata == {1'b0, $past(m1)}) else $error("mode 1 readback");
    a_count_low_read: assert property (
        ra == CCA_ADDR_CNT_LO |=> sfr_rdata == $past(cnt[7:0])) else $error("counter low read");
    a_count_high_read: assert property (
        ra == CCA_ADDR_CNT_HI |=> sfr_rdata == $past(cnt[15:8])) else $error("counter high read");
    a_run_bit_read: assert property (
        ra == CCA_ADDR_CONTROL |=> sfr_rdata[6] == $past(run)) else $error("run bit read");
    a_irq_gate_mode: assert property (
        (module_irq_request[1:0] & ~$past({m1[0], m0[0]})) == 2'b00) else $error("ungated irq");
    a_match_pin_toggle: assert property (
        s_match0 |=> module_io_pin_out[0] != $past(module_io_pin_out[0])) else $error("no toggle");
    a_pin_quiet_idle: assert property (
        s_quiet0 ##1 s_quiet0 |-> $stable(module_io_pin_out[0])) else $error("pin moved");
endmodule // cca_chk

bind cca_top cca_chk #(.NUM_MOD(NUM_MOD)) u_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .module_io_pin_in(module_io_pin_in),
    .module_io_pin_out(module_io_pin_out), .module_io_pin_oe(module_io_pin_oe),
    .module_irq_request(module_irq_request));

//--- test/cca_pin_model.sv
// Far side of the module pins: external levels with a reaction lag, pulled up when idle
module cca_pin_model #(
    parameter int LAG = 1
) (
    input  wire logic       clk,
    input  wire logic [1:0] level_req,
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    output logic      [1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] dl [LAG+1] = '{default: 2'b11};
    // Delay line: a slow source shows its edge only after LAG+1 cycles
    always @(posedge clk) begin
        dl[0] <= level_req;
        for (int i = 1; i <= LAG; i++) dl[i] <= dl[i-1];
    end
    // A driven pin shows the block's level, else the external source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & dl[LAG]);
endmodule // cca_pin_model

//--- test/testbench.sv
// Self-checking bench: register access, counter, compare, capture and PWM
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h, expected %h", $time, (g), (e)); end end
module testbench
    import cca_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       ce = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic [7:0] sfr_rdata, v;
    logic [1:0] pin_in, pin_out, pin_oe, irq;
    logic [1:0] level_req = 2'b11;
    logic       p;
    int         err_count = 0;
    int         checks = 0;
    int         highs;

    always #20 clk = ~clk;

    cca_top #(.NUM_MOD(2)) dut (.clk(clk), .rst_n(rst_n), .ce(ce), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
        .module_io_pin_oe(pin_oe), .module_irq_request(irq));
    cca_pin_model #(.LAG(3)) u_pins (.clk(clk), .level_req(level_req), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in));

    // ------------------------------
    // Bus tasks
    // ------------------------------
    // Strobes rise and fall on falling edges, one strobe per two cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        v      = sfr_rdata;
        `CHK(v, e)
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        wrap_up;
    end

    // ------------------------------
    // Test sequence
    // ------------------------------
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rc(CCA_ADDR_MODE0, 8'h00);
        rc(CCA_ADDR_MODE1, 8'h00);
        rc(CCA_ADDR_CNT_LO, 8'h00);
        rc(CCA_ADDR_CNT_HI, 8'h00);
        rc(CCA_ADDR_CONTROL, 8'h00);
        wr(CCA_ADDR_MODE1, 8'hFF);
        rc(CCA_ADDR_MODE1, 8'h7F);
        wr(CCA_ADDR_MODE1, 8'h00);
        // Stopped counter keeps written bytes; run for 12 counted edges
        wr(CCA_ADDR_CNT_HI, 8'h12);
        wr(CCA_ADDR_CNT_LO, 8'h34);
        idle(20);
        rc(CCA_ADDR_CNT_HI, 8'h12);
        rc(CCA_ADDR_CNT_LO, 8'h34);
        wr(CCA_ADDR_CONTROL, 8'h40);
        idle(10);
        wr(CCA_ADDR_CONTROL, 8'h00);
        rc(CCA_ADDR_CNT_LO, 8'h40);
        // Clock enable low freezes the running counter: 2 counted edges, not 12
        wr(CCA_ADDR_CONTROL, 8'h40);
        ce = 1'b0;
        idle(10);
        ce = 1'b1;
        wr(CCA_ADDR_CONTROL, 8'h00);
        rc(CCA_ADDR_CNT_LO, 8'h42);
        // Toggle compare at 0010 with interrupt enabled
        wr(CCA_ADDR_CNT_LO, 8'h00);
        wr(CCA_ADDR_CNT_HI, 8'h00);
        wr(CCA_ADDR_CAP0_LO, 8'h10);
        wr(CCA_ADDR_CAP0_HI, 8'h00);
        wr(CCA_ADDR_MODE0, 8'h4D);
        idle(2);
        p = pin_out[0];
        `CHK(pin_oe[0], 1'b1)
        wr(CCA_ADDR_CONTROL, 8'h40);
        idle(30);
        rc(CCA_ADDR_CONTROL, 8'h41);
        `CHK(pin_out[0], ~p)
        `CHK(irq[0], 1'b1)
        wr(CCA_ADDR_MODE0, 8'h4C);
        idle(2);
        `CHK(irq[0], 1'b0)
        rc(CCA_ADDR_CONTROL, 8'h41);
        wr(CCA_ADDR_CONTROL, 8'h00);
        rc(CCA_ADDR_CONTROL, 8'h00);
        wr(CCA_ADDR_MODE0, 8'h00);
        // Low byte alone equal to the compare pair, then compare disabled: no flag
        wr(CCA_ADDR_CNT_LO, 8'h00);
        wr(CCA_ADDR_CNT_HI, 8'h00);
        wr(CCA_ADDR_CAP0_HI, 8'h01);
        wr(CCA_ADDR_MODE0, 8'h4D);
        wr(CCA_ADDR_CONTROL, 8'h40);
        idle(30);
        rc(CCA_ADDR_CONTROL, 8'h40);
        wr(CCA_ADDR_CONTROL, 8'h00);
        wr(CCA_ADDR_CNT_LO, 8'h00);
        wr(CCA_ADDR_CAP0_HI, 8'h00);
        wr(CCA_ADDR_MODE0, 8'h0D);
        wr(CCA_ADDR_CONTROL, 8'h40);
        idle(30);
        rc(CCA_ADDR_CONTROL, 8'h40);
        wr(CCA_ADDR_CONTROL, 8'h00);
        wr(CCA_ADDR_MODE0, 8'h00);
        // Capture on module 1: rise mode ignores a falling edge and takes a rising one, then fall mode takes a falling edge
        wr(CCA_ADDR_CNT_HI, 8'hAB);
        wr(CCA_ADDR_CNT_LO, 8'hCD);
        wr(CCA_ADDR_MODE1, 8'h20);
        level_req[1] = 1'b0;
        idle(10);
        rc(CCA_ADDR_CONTROL, 8'h00);
        level_req[1] = 1'b1;
        idle(10);
        rc(CCA_ADDR_CONTROL, 8'h02);
        rc(CCA_ADDR_CAP1_HI, 8'hAB);
        rc(CCA_ADDR_CAP1_LO, 8'hCD);
        wr(CCA_ADDR_CONTROL, 8'h00);
        wr(CCA_ADDR_MODE1, 8'h10);
        wr(CCA_ADDR_CNT_LO, 8'h01);
        level_req[1] = 1'b0;
        idle(10);
        rc(CCA_ADDR_CAP1_LO, 8'h01);
        rc(CCA_ADDR_CONTROL, 8'h02);
        // PWM at half duty over one full low-byte period
        wr(CCA_ADDR_CNT_LO, 8'h00);
        wr(CCA_ADDR_CAP0_HI, 8'h80);
        wr(CCA_ADDR_CAP0_LO, 8'h80);
        wr(CCA_ADDR_MODE0, 8'h42);
        wr(CCA_ADDR_CONTROL, 8'h40);
        idle(4);
        highs = 0;
        repeat (256) begin
            @(negedge clk);
            highs += int'(pin_out[0]);
        end
        `CHK(highs, 128)
        `CHK(pin_oe[0], 1'b1)
        // New duty in the high byte reaches the low byte at the next wrap
        wr(CCA_ADDR_CAP0_HI, 8'h40);
        idle(260);
        rc(CCA_ADDR_CAP0_LO, 8'h40);
        wr(CCA_ADDR_CONTROL, 8'h00);
        wrap_up;
    end
endmodule // testbench
